// ---- inc/dac_front_pkg.sv ----
// Package for the serial front end and monitor mux of a multichannel DAC.
// Assumes a single system clock domain; the link clock is sampled as data.
package dac_front_pkg;
    // ------------------------------------------------------------------
    // Frame and word layout
    // ------------------------------------------------------------------
    localparam int          WORD_BITS    = 24;
    localparam int          CNT_W        = 5;
    localparam logic [4:0]  WORD_BITS_C  = 5'h18;
    localparam int          DATA_W       = 16;
    localparam int          ADDR_LSB     = 16;
    localparam int          ADDR_W       = 5;
    localparam int          REG_LSB      = 21;
    localparam int          REG_W        = 2;
    localparam logic        RD_BIT_POS   = 1'h1;
    localparam int          RD_BIT       = 23;
    // Special function register select: reg field zero, address 0x0C control, 0x0A monitor
    localparam logic [1:0]  REG_SFR      = 2'h0;
    localparam logic [4:0]  SFR_CONTROL  = 5'h0C;
    localparam logic [4:0]  SFR_MONITOR  = 5'h0A;
    // ------------------------------------------------------------------
    // Control register fields (two bit maps for the two word widths)
    // ------------------------------------------------------------------
    localparam int          CR_W         = 14;
    localparam logic [13:0] CR_RESET     = 14'h0000;
    localparam int          CR14_REFV    = 12;
    localparam int          CR14_REFSEL  = 10;
    localparam int          CR14_MON_EN  = 9;
    localparam int          CR12_REFV    = 10;
    localparam int          CR12_REFSEL  = 8;
    localparam int          CR12_MON_EN  = 7;
    // ------------------------------------------------------------------
    // Monitor channel codes
    // ------------------------------------------------------------------
    localparam int          MON_W        = 6;
    localparam logic [5:0]  MON_NONE     = 6'h3F;
    localparam logic [5:0]  MON_IN_A     = 6'h10;
    localparam logic [5:0]  MON_IN_B     = 6'h11;
    localparam logic [5:0]  MON_LAST_DAC = 6'h0F;
    // ------------------------------------------------------------------
    // Busy time after reset
    // ------------------------------------------------------------------
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          BUSY_US      = 270;
    localparam int          BUSY_CYCLES  = (BUSY_US * (CLK_HZ / 1_000_000));
    typedef enum logic [1:0] {ST_BUSY, ST_IDLE, ST_SHIFT} link_state_type;
endpackage : dac_front_pkg

// ---- inc/word_if.sv ----
// Interface carrying a decoded serial word from the link to the registers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface word_if;
    logic        valid;
    logic [23:0] word;
    logic [23:0] rdata;
    modport link (output valid, output word, input rdata);
    modport regs (input valid, input word, output rdata);
endinterface : word_if
`default_nettype wire

// ---- core/serial_link.sv ----
// Serial shift engine: samples link pins, shifts in on falling, out on rising.
// Assumes pins are asynchronous to clock; link clock well below clock rate.
`timescale 1ns/1ps
`default_nettype none
module serial_link (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Gate from reset sequencer
    input  wire logic ready,
    // Link pins
    input  wire logic shift_clock,
    input  wire logic frame_n,
    input  wire logic serial_in,
    output logic      serial_out,
    // Word path
    word_if.link      wp
);
    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [2:0] s1_q, s2_q, s1_d, s2_d;
    logic       sclk_old_q, sclk_old_d;
    logic [dac_front_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [23:0] sh_q, sh_d, out_q, out_d;
    logic        so_q, so_d, val_q, val_d;
    logic        fall, rise, fr;

    always_comb begin
        s1_d       = {shift_clock, frame_n, serial_in};
        s2_d       = s1_q;
        sclk_old_d = s2_q[2];
        fall       = sclk_old_q & ~s2_q[2];
        rise       = ~sclk_old_q & s2_q[2];
        fr         = ~s2_q[1] & ready;
        cnt_d      = cnt_q;
        sh_d       = sh_q;
        out_d      = out_q;
        so_d       = so_q;
        val_d      = 1'b0;
        if (!fr) begin
            // Frame end or busy: abandon partial word, reload readback
            cnt_d = '0;
            out_d = wp.rdata;
            so_d  = wp.rdata[23];
        end else begin
            if (fall) begin
                sh_d  = {sh_q[22:0], s2_q[0]};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == dac_front_pkg::WORD_BITS_C - 5'h01) begin
                    val_d = 1'b1;
                    cnt_d = '0;
                end
            end
            if (rise) begin
                so_d  = out_q[23];
                out_d = {out_q[22:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // Idle levels: link clock low, frame high, so no false edge
            s1_q       <= 3'h2;
            s2_q       <= 3'h2;
            sclk_old_q <= 1'b0;
            cnt_q      <= '0;
            sh_q       <= '0;
            out_q      <= '0;
            so_q       <= 1'b0;
            val_q      <= 1'b0;
        end else begin
            s1_q       <= s1_d;
            s2_q       <= s2_d;
            sclk_old_q <= sclk_old_d;
            cnt_q      <= cnt_d;
            sh_q       <= sh_d;
            out_q      <= out_d;
            so_q       <= so_d;
            val_q      <= val_d;
        end
    end

    assign wp.valid   = val_q;
    assign wp.word    = sh_q;
    assign serial_out = so_q;
endmodule : serial_link
`default_nettype wire

// ---- core/dac_front.sv ----
// Top of the DAC host front end: serial link, control register, monitor mux.
// Assumes link pins are asynchronous; analog switching is done outside.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Serial bits captured on falling clock edge, readback shifted on rising edge.
// - External reference selected after power-up until software enables internal.
// - Wide variant: bit 12 picks voltage, bit 10 picks internal reference.
// - Narrow variant: bit 10 picks voltage, bit 8 picks internal reference.
// - Monitor routes a channel only once monitor enable is set.
// - Monitor channel 63 floats the monitor output.
// - Monitor can select either external monitor input.
// - Monitor output floats while monitor enable is clear.
// - Serial activity and load pulses ignored while busy is low.
module dac_front #(
    parameter int BUSY_COUNT = dac_front_pkg::BUSY_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Variant strap: high for 12-bit control map
    input  wire logic        narrow_variant,
    // Serial link
    input  wire logic        shift_clock,
    input  wire logic        frame_n,
    input  wire logic        serial_in,
    output logic             serial_out,
    // Load pin
    input  wire logic        load_dac_n,
    output logic             load_pulse,
    // Status
    output logic             busy_n,
    // Reference control
    output logic             reference_internal,
    output logic             reference_high,
    // Monitor mux
    output logic [5:0]       monitor_select,
    output logic             monitor_output_oe,
    output logic             monitor_input_a_sel,
    output logic             monitor_input_b_sel,
    // Last data word for the DAC core
    output logic             data_write,
    output logic [23:0]      data_word
);
    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    logic [19:0] busy_cnt_q, busy_cnt_d;
    logic        busy_n_q, busy_n_d;
    logic        narrow_q, narrow_d;
    logic        strap_s1_q, strap_s1_d, strap_s2_q, strap_s2_d;

    always_comb begin
        busy_cnt_d = busy_cnt_q;
        busy_n_d   = busy_n_q;
        narrow_d   = narrow_q;
        // Strap is a pin: three flops before the mux reads it
        strap_s1_d = narrow_variant;
        strap_s2_d = strap_s1_q;
        if (!busy_n_q) begin
            narrow_d = strap_s2_q; // Strap caught while busy
            if (busy_cnt_q == 20'(BUSY_COUNT - 1)) begin
                busy_n_d = 1'b1;
            end else begin
                busy_cnt_d = busy_cnt_q + 20'h00001;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_q <= 20'h00000;
            busy_n_q   <= 1'b0;
            narrow_q   <= 1'b0;
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
            busy_n_q   <= busy_n_d;
            narrow_q   <= narrow_d;
            strap_s1_q <= strap_s1_d;
            strap_s2_q <= strap_s2_d;
        end
    end

    // ------------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------------
    word_if wp ();

    serial_link u_link (
        .clock       (clock),
        .reset_n     (reset_n),
        .ready       (busy_n_q),
        .shift_clock (shift_clock),
        .frame_n     (frame_n),
        .serial_in   (serial_in),
        .serial_out  (serial_out),
        .wp          (wp)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [13:0] cr_q, cr_d;
    logic [5:0]  mon_q, mon_d;
    logic [2:0]  ld_q, ld_d;
    logic        lp_q, lp_d, wr_q, wr_d;
    logic [23:0] dw_q, dw_d;
    logic        is_sfr, rd;
    logic [4:0]  addr;
    logic [5:0]  chan;
    logic        refv, refsel, mon_en;

    always_comb begin
        is_sfr = wp.word[dac_front_pkg::REG_LSB +: dac_front_pkg::REG_W]
                 == dac_front_pkg::REG_SFR;
        rd     = wp.word[dac_front_pkg::RD_BIT];
        addr   = wp.word[dac_front_pkg::ADDR_LSB +: dac_front_pkg::ADDR_W];
        chan   = wp.word[dac_front_pkg::MON_W-1:0];
        cr_d   = cr_q;
        mon_d  = mon_q;
        dw_d   = dw_q;
        wr_d   = 1'b0;
        ld_d   = {ld_q[1:0], load_dac_n};
        lp_d   = busy_n_q & ld_q[2] & ~ld_q[1];
        if (wp.valid && !rd) begin
            if (is_sfr && addr == dac_front_pkg::SFR_CONTROL) begin
                cr_d = wp.word[dac_front_pkg::CR_W-1:0];
            end else if (is_sfr && addr == dac_front_pkg::SFR_MONITOR) begin
                if (chan <= dac_front_pkg::MON_LAST_DAC || chan == dac_front_pkg::MON_IN_A
                    || chan == dac_front_pkg::MON_IN_B || chan == dac_front_pkg::MON_NONE) begin
                    mon_d = chan;
                end
            end else begin
                dw_d = wp.word;
                wr_d = 1'b1;
            end
        end
        if (narrow_q) begin
            refv   = cr_q[dac_front_pkg::CR12_REFV];
            refsel = cr_q[dac_front_pkg::CR12_REFSEL];
            mon_en = cr_q[dac_front_pkg::CR12_MON_EN];
        end else begin
            refv   = cr_q[dac_front_pkg::CR14_REFV];
            refsel = cr_q[dac_front_pkg::CR14_REFSEL];
            mon_en = cr_q[dac_front_pkg::CR14_MON_EN];
        end
    end

    // Readback returns control register; DAC data lives outside this block
    assign wp.rdata = {10'h000, cr_q};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cr_q  <= dac_front_pkg::CR_RESET;
            mon_q <= dac_front_pkg::MON_NONE;
            ld_q  <= 3'h7;
            lp_q  <= 1'b0;
            wr_q  <= 1'b0;
            dw_q  <= 24'h000000;
        end else begin
            cr_q  <= cr_d;
            mon_q <= mon_d;
            ld_q  <= ld_d;
            lp_q  <= lp_d;
            wr_q  <= wr_d;
            dw_q  <= dw_d;
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    logic       ri_q, rh_q, oe_q, ia_q, ib_q;
    logic       ri_d, rh_d, oe_d, ia_d, ib_d;
    logic [5:0] ms_q, ms_d;

    always_comb begin
        ri_d = refsel;
        rh_d = refv;
        oe_d = mon_en && mon_q != dac_front_pkg::MON_NONE;
        ms_d = mon_q;
        ia_d = oe_d && mon_q == dac_front_pkg::MON_IN_A;
        ib_d = oe_d && mon_q == dac_front_pkg::MON_IN_B;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ri_q <= 1'b0;
            rh_q <= 1'b0;
            oe_q <= 1'b0;
            ia_q <= 1'b0;
            ib_q <= 1'b0;
            ms_q <= dac_front_pkg::MON_NONE;
        end else begin
            ri_q <= ri_d;
            rh_q <= rh_d;
            oe_q <= oe_d;
            ia_q <= ia_d;
            ib_q <= ib_d;
            ms_q <= ms_d;
        end
    end

    assign busy_n              = busy_n_q;
    assign reference_internal  = ri_q;
    assign reference_high      = rh_q;
    assign monitor_output_oe   = oe_q;
    assign monitor_select      = ms_q;
    assign monitor_input_a_sel = ia_q;
    assign monitor_input_b_sel = ib_q;
    assign load_pulse          = lp_q;
    assign data_write          = wr_q;
    assign data_word           = dw_q;
endmodule : dac_front
`default_nettype wire

// ---- test/dac_front_checker.sv ----
// Port checker for the DAC host front end.
// Assumes one clock domain; bound to every dac_front instance.
`timescale 1ns/1ps
`default_nettype none
module dac_front_checker #(parameter int BUSY_COUNT = 8) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    // Watched pins
    input wire logic       load_dac_n,
    input wire logic       load_pulse,
    input wire logic       busy_n,
    input wire logic       reference_internal,
    input wire logic [5:0] monitor_select,
    input wire logic       monitor_output_oe,
    input wire logic       monitor_input_a_sel,
    input wire logic       monitor_input_b_sel,
    input wire logic       data_write
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Saturates so it never wraps on long runs
    int up_q;
    int up_d;
    always_comb up_d = (up_q < BUSY_COUNT + 4) ? up_q + 1 : up_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) up_q <= 0;
        else up_q <= up_d;
    end
    property p_busy_hold; up_q < BUSY_COUNT |-> !busy_n; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy ended early");
    property p_busy_end; up_q >= BUSY_COUNT + 3 |-> busy_n; endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy stuck low");
    property p_quiet; !busy_n |-> !data_write && !load_pulse; endproperty
    a_quiet: assert property (p_quiet) else $error("activity while busy");
    property p_boot; !busy_n |-> !reference_internal && !monitor_output_oe; endproperty
    a_boot: assert property (p_boot) else $error("boot state wrong");
    property p_off; monitor_output_oe |-> monitor_select != 6'h3F; endproperty
    a_off: assert property (p_off) else $error("code 63 driven");
    property p_in_a;
        monitor_input_a_sel |-> monitor_select == 6'h10 && !monitor_input_b_sel;
    endproperty
    a_in_a: assert property (p_in_a) else $error("input a select wrong");
    property p_in_b; monitor_input_b_sel |-> monitor_select == 6'h11; endproperty
    a_in_b: assert property (p_in_b) else $error("input b select wrong");
    property p_known; monitor_select <= 6'h11 || monitor_select == 6'h3F; endproperty
    a_known: assert property (p_known) else $error("unknown code taken");
    property p_load; busy_n && $fell(load_dac_n) |-> ##[1:8] load_pulse; endproperty
    a_load: assert property (p_load) else $error("load pulse missing");
    c_in_a: cover property (monitor_output_oe && monitor_input_a_sel);
    c_write: cover property (data_write);
    c_load: cover property (load_pulse);
endmodule : dac_front_checker
bind dac_front dac_front_checker #(.BUSY_COUNT(BUSY_COUNT)) chk (
    .clock(clock), .reset_n(reset_n), .load_dac_n(load_dac_n), .load_pulse(load_pulse),
    .busy_n(busy_n), .reference_internal(reference_internal),
    .monitor_select(monitor_select), .monitor_output_oe(monitor_output_oe),
    .monitor_input_a_sel(monitor_input_a_sel), .monitor_input_b_sel(monitor_input_b_sel),
    .data_write(data_write));
`default_nettype wire

// ---- test/host_model.sv ----
// Host serial master: frames words, sends MSB first, captures readback.
// Assumes the bench clock; link half period is four clocks.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic clock,
    // Link pins
    output logic      shift_clock,
    output logic      frame_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    initial begin
        shift_clock = 1'b0;
        frame_n = 1'b1;
        serial_in = 1'b0;
    end
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        r = 24'h000000;
        // Long idle so the frame edge survives synchronising
        repeat (4) @(posedge clock);
        frame_n <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 23; i >= 0; i--) begin
            if (i % 8 == 7 && i != 23) repeat (4) @(posedge clock);
            serial_in <= w[i];
            shift_clock <= 1'b1;
            repeat (4) @(posedge clock);
            shift_clock <= 1'b0;
            repeat (4) @(posedge clock);
            r[i] = serial_out;
        end
        frame_n <= 1'b1;
        // Released line shows the inverse, not a stale bit
        serial_in <= ~w[0];
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ---- test/dac_front_bench.sv ----
// Bench for the DAC front end: reset, control, monitor, readback, load.
// Assumes host_model on the link and a shortened busy time.
`timescale 1ns/1ps
`default_nettype none
module dac_front_bench;
    localparam int BUSY = 300;
    logic clock, reset_n, narrow_variant, load_dac_n, load_pulse, busy_n;
    logic shift_clock, frame_n, serial_in, serial_out, data_write;
    logic reference_internal, reference_high, monitor_output_oe;
    logic monitor_input_a_sel, monitor_input_b_sel;
    logic [5:0] monitor_select;
    logic [23:0] data_word, rd;
    logic [15:0] cr;
    int num_errors = 0, check_count = 0, cycles = 0, rv, rs, me;
    int write_count = 0, load_count = 0, mark_w, mark_l;
    dac_front #(.BUSY_COUNT(BUSY)) uut (.clock(clock), .reset_n(reset_n),
        .narrow_variant(narrow_variant), .shift_clock(shift_clock), .frame_n(frame_n),
        .serial_in(serial_in), .serial_out(serial_out), .load_dac_n(load_dac_n),
        .load_pulse(load_pulse), .busy_n(busy_n), .reference_internal(reference_internal),
        .reference_high(reference_high), .monitor_select(monitor_select),
        .monitor_output_oe(monitor_output_oe), .monitor_input_a_sel(monitor_input_a_sel),
        .monitor_input_b_sel(monitor_input_b_sel), .data_write(data_write),
        .data_word(data_word));
    host_model host (.clock(clock), .shift_clock(shift_clock), .frame_n(frame_n),
        .serial_in(serial_in), .serial_out(serial_out));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (data_write === 1'b1) write_count <= write_count + 1;
        if (load_pulse === 1'b1) load_count <= load_count + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic put(input logic [4:0] a, input logic [15:0] d);
        host.xfer({1'b0, dac_front_pkg::REG_SFR, a, d}, rd);
        repeat (10) @(posedge clock);
    endtask : put
    task automatic mon(input logic [5:0] code, input logic [8:0] exp);
        put(dac_front_pkg::SFR_MONITOR, {10'h000, code});
        check({15'h0000, monitor_input_a_sel, monitor_input_b_sel, monitor_output_oe,
            monitor_select}, {15'h0000, exp});
    endtask : mon
    task automatic reboot(input logic nv);
        narrow_variant <= nv;
        reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        check({14'h0000, busy_n, monitor_output_oe, reference_internal, reference_high,
            monitor_select}, {14'h0000, 4'h0, 6'h3F});
        mark_l = load_count;
        reset_n <= 1'b1;
        load_dac_n <= 1'b0;
        @(posedge clock);
        load_dac_n <= 1'b1;
        // Frame sent while busy must be dropped
        put(dac_front_pkg::SFR_CONTROL, 16'hFFFF);
        for (int k = 0; k < 400 && busy_n !== 1'b1; k++) @(posedge clock);
        check({21'h000000, busy_n, reference_internal, reference_high}, 24'h000004);
        check(24'(load_count - mark_l), 24'h000000);
    endtask : reboot
    initial begin
        reset_n = 1'b0;
        narrow_variant = 1'b0;
        load_dac_n = 1'b1;
        for (int nv = 0; nv < 2; nv++) begin
            rv = nv ? dac_front_pkg::CR12_REFV : dac_front_pkg::CR14_REFV;
            rs = nv ? dac_front_pkg::CR12_REFSEL : dac_front_pkg::CR14_REFSEL;
            me = nv ? dac_front_pkg::CR12_MON_EN : dac_front_pkg::CR14_MON_EN;
            reboot(nv[0]);
            cr = 16'h0000;
            cr[rv] = 1'b1;
            cr[rs] = 1'b1;
            put(dac_front_pkg::SFR_CONTROL, cr);
            check({22'h000000, reference_internal, reference_high}, 24'h000003);
            put(dac_front_pkg::SFR_MONITOR, 16'h0003);
            check({23'h000000, monitor_output_oe}, 24'h000000);
            cr[me] = 1'b1;
            put(dac_front_pkg::SFR_CONTROL, cr);
            check({18'h00000, monitor_select}, 24'h000003);
            check({23'h000000, monitor_output_oe}, 24'h000001);
            mon(6'h10, {3'h5, 6'h10});
            mon(6'h11, {3'h3, 6'h11});
            mon(6'h14, {3'h3, 6'h11});
            mon(6'h3F, {3'h0, 6'h3F});
            host.xfer({1'b1, dac_front_pkg::REG_SFR, dac_front_pkg::SFR_CONTROL, 16'h0000}, rd);
            repeat (10) @(posedge clock);
            check(rd, {10'h000, cr[13:0]});
            check({22'h000000, reference_internal, reference_high}, 24'h000003);
            mark_w = write_count;
            host.xfer({1'b0, 2'h1, 5'h03, 16'hA55A}, rd);
            repeat (10) @(posedge clock);
            check(data_word, {1'b0, 2'h1, 5'h03, 16'hA55A});
            mark_l = load_count;
            load_dac_n <= 1'b0;
            repeat (12) @(posedge clock);
            load_dac_n <= 1'b1;
            check(24'(write_count - mark_w), 24'h000001);
            check(24'(load_count - mark_l), 24'h000001);
        end
        summarize();
    end
endmodule : dac_front_bench
`default_nettype wire
